// ---- rtl/pmc_cfg.svh ----
// offsets, field positions, reset values and timing counts of the power mode controller
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// register indices; byte address is four times the index
`define PMC_ADDR_W          18
`define PMC_IDX_DIV         16'hffa1
`define PMC_IDX_ROUTE       16'hff94
`define PMC_IDX_MISC0       16'hfff1
`define PMC_IDX_CARD        16'hfe00

// field positions
`define PMC_DIV_LSB         0
`define PMC_DIV_W           6
`define PMC_PDN_BIT         7
`define PMC_ROUTE_BIT       7
`define PMC_CARD_PDN_BIT    0
`define PMC_ST_ON_BIT       4
`define PMC_ST_OFFREQ_BIT   5
`define PMC_ST_BUS_BIT      6
`define PMC_ST_STBY_BIT     7

// reset values
`define PMC_DIV_RST         6'h0c

// timing
`define PMC_PD_DELAY_TICKS  32
`define PMC_WAKE_TICKS      512
`define PMC_CLK_PERIOD_NS   25
`define PMC_DEBOUNCE_MS     50
`define PMC_DEBOUNCE_CYC    ((`PMC_DEBOUNCE_MS * 1000000 + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_DEB_W           24
`define PMC_TICK_W          10

// bus answers
`define PMC_RESP_OKAY       2'h0
`define PMC_RESP_SLVERR     2'h2

`endif

// ---- rtl/pmc_clkdiv.sv ----
// processor clock divider: half period of div+1 master clocks
`timescale 1ns/100ps
`default_nettype none
`include "pmc_cfg.svh"

module pmc_clkdiv
  import pmc_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  // divider field
  input  wire logic [`PMC_DIV_W-1:0] i_div,
  // divided clock and its rising-edge pulse
  output logic                       o_proc_clk,
  output logic                       o_tick
);

  pmc_div_state_t q;
  pmc_div_state_t d;

  // count to div, then toggle; >= lets a smaller new value take effect at once
  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt >= i_div) begin
      d.cnt  = '0;
      d.clk  = ~q.clk;
      d.tick = ~q.clk;
    end else begin
      d.cnt = q.cnt + `PMC_DIV_W'(1);
    end
  end

  // registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_proc_clk = q.clk;
  assign o_tick     = q.tick;

endmodule

`default_nettype wire

// ---- rtl/pmc_pkg.sv ----
// types shared by the power mode controller files
`include "pmc_cfg.svh"

package pmc_pkg;

  // on/off mode of the supply logic
  typedef enum logic [1:0] {
    OO_OFF = 2'b01,
    OO_ON  = 2'b10
  } pmc_onoff_t;

  // power-down sequencer
  typedef enum logic [3:0] {
    PD_RUN   = 4'b0001,
    PD_DELAY = 4'b0010,
    PD_DOWN  = 4'b0100,
    PD_WAKE  = 4'b1000
  } pmc_pd_t;

  // axi4-lite master to slave
  typedef struct packed {
    logic [`PMC_ADDR_W-1:0] awaddr;
    logic                   awvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   wvalid;
    logic                   bready;
    logic [`PMC_ADDR_W-1:0] araddr;
    logic                   arvalid;
    logic                   rready;
  } pmc_axi_req_t;

  // axi4-lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } pmc_axi_rsp_t;

  // clock divider state
  typedef struct packed {
    logic [`PMC_DIV_W-1:0] cnt;
    logic                  clk;
    logic                  tick;
  } pmc_div_state_t;

  // top level state
  typedef struct packed {
    pmc_onoff_t             mode;
    pmc_pd_t                pd;
    logic [`PMC_DIV_W-1:0]  div;
    logic                   pdn;
    logic                   route;
    logic                   card_pdn;
    logic                   off_req;
    logic                   deb;
    logic [`PMC_DEB_W-1:0]  deb_cnt;
    logic [`PMC_TICK_W-1:0] tick_cnt;
    logic                   bus_sw;
    logic                   bat_sw;
    logic                   core_en;
    logic                   core_por;
    logic                   conv_en;
    logic                   analog_en;
    logic                   cpu_halt;
    logic                   card_deact;
    logic                   external_interrupt_zero;
    logic                   aw_hold;
    logic [15:0]            aw_idx;
    logic                   w_hold;
    logic [7:0]             wdata;
    logic                   wstrb0;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [7:0]             rdata;
    logic [1:0]             rresp;
  } pmc_state_t;

endpackage

// ---- rtl/pmc_sync.sv ----
// three-flop pin synchroniser with a second/third agreement filter
`timescale 1ns/100ps
`default_nettype none

module pmc_sync #(
  parameter int         W   = 2,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // asynchronous pins
  input  wire logic [W-1:0] i_pin,
  // filtered level
  output logic      [W-1:0] o_level
);

  // all state of the synchroniser
  typedef struct packed {
    logic [W-1:0] s1;   // first stage, read only by s2
    logic [W-1:0] s2;   // second stage
    logic [W-1:0] s3;   // third stage
    logic [W-1:0] lvl;  // accepted level
  } pmc_sync_state_t;

  pmc_sync_state_t q;
  pmc_sync_state_t d;

  // a change counts once the second and third stages agree
  always_comb begin
    d     = q;
    d.s1  = i_pin;
    d.s2  = q.s1;
    d.s3  = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  // registers; reset level is a constant so the far side sees a defined value
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q.s1  <= RST;
      q.s2  <= RST;
      q.s3  <= RST;
      q.lvl <= RST;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.lvl;

endmodule

`default_nettype wire

// ---- rtl/pmc_top.sv ----
// power mode sequencer with processor clock divider and axi4-lite registers
//
// Operation
// - processor clock is master over 2*(div+1)
// - divider field resets to twelve
// - bus supply preferred, switches never both on
// - switch in off powers core, holds reset
// - switch in on only requests shutdown
// - bus supply present forces on, switch ignored
// - no bus supply: start off, obey switch
// - off to on after debounced switch low
// - long press in on latches shutdown request
// - card power-down deactivates card, cuts supplies
// - card power-down anytime goes off without bus
// - grounded switch turns core on automatically
// - bus removed while on: battery, stay on
// - standby halts core, clocks and peripherals; here only o_cpu_halt, processor clock runs on
// - power-down with bus or on gives standby
// - power-down when off without bus stops converter
// - analog shut down 32 processor clocks later
// - three interrupt groups ored wake to external_interrupt_zero
// - external_interrupt_zero presented after 512 processor clocks
// - reading routing register clears routing bit
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_cfg.svh"

module pmc_top
  import pmc_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = `PMC_DEBOUNCE_CYC  // debounce length in clocks
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // register bus
  input  wire pmc_axi_req_t i_axi,
  output pmc_axi_rsp_t      o_axi,
  // pins from the switch and supply detector
  input  wire logic         i_onoff_n,
  input  wire logic         i_bus_present,
  // wake interrupt groups, same clock
  input  wire logic         i_usr_int,
  input  wire logic         i_card_int,
  input  wire logic         i_keypad_int,
  // clocks and supplies
  output logic              o_proc_clk,
  output logic              o_bus_sw_en,
  output logic              o_bat_sw_en,
  output logic              o_core_supply_en,
  output logic              o_core_por,
  output logic              o_converter_en,
  output logic              o_analog_en,
  // processor side
  output logic              o_cpu_halt,
  output logic              o_card_deact,
  output logic              o_off_req,
  output logic              o_ext_external_interrupt_zero
);

  pmc_state_t q;          // registered state
  pmc_state_t n;          // next state
  logic [1:0] sync_lvl;   // filtered pins
  logic       sw_n;       // switch level, low when pressed
  logic       bus_s;      // bus supply present
  logic       tick;       // processor clock rising edge
  logic       wake_any;   // ored wake groups

  // true when a word index hits one of our registers
  function automatic logic is_mapped(input logic [15:0] idx);
    is_mapped = (idx == `PMC_IDX_DIV) || (idx == `PMC_IDX_ROUTE) ||
                (idx == `PMC_IDX_MISC0) || (idx == `PMC_IDX_CARD);
  endfunction

  // pins cross in through three flops
  pmc_sync #(
    .W   (2),
    .RST (2'b01)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_pin    ({i_bus_present, i_onoff_n}),
    .o_level  (sync_lvl)
  );

  assign sw_n  = sync_lvl[0];
  assign bus_s = sync_lvl[1];

  // divider runs off the live field
  pmc_clkdiv u_div (
    .i_clk      (i_clk),
    .i_arst_n   (i_arst_n),
    .i_div      (q.div),
    .o_proc_clk (o_proc_clk),
    .o_tick     (tick)
  );

  assign wake_any = i_usr_int | i_card_int | i_keypad_int;

  // next-state logic
  always_comb begin
    n = q;

    // debounce: any disagreement must last the full count; a bounce restarts it
    if (sw_n != q.deb) begin
      if (q.deb_cnt >= `PMC_DEB_W'(DEBOUNCE_CYC - 1)) begin
        n.deb     = sw_n;
        n.deb_cnt = '0;
      end else begin
        n.deb_cnt = q.deb_cnt + `PMC_DEB_W'(1);
      end
    end else begin
      n.deb_cnt = '0;
    end

    // on/off mode
    unique case (q.mode)
      OO_OFF: begin
        // bus supply forces on; otherwise only the debounced switch counts
        if (bus_s || !n.deb) begin
          n.mode = OO_ON;
        end
      end
      OO_ON: begin
        if (!bus_s && q.card_pdn && q.card_deact) begin
          // card already deactivated: drop core and analog supplies
          n.mode     = OO_OFF;
          n.card_pdn = 1'b0;
          n.off_req  = 1'b0;
          n.pdn      = 1'b0;
          n.pd       = PD_RUN;
        end else if (!bus_s && q.deb && !n.deb) begin
          // press while on only raises the request; stays latched
          n.off_req = 1'b1;
        end
        // losing bus supply keeps us on, battery takes over below
      end
    endcase

    // break-before-make: a switch only closes once the other is open
    n.bus_sw = bus_s && !q.bat_sw;
    n.bat_sw = !bus_s && !q.bus_sw;

    // power-down sequencer, counted in processor clocks
    unique case (q.pd)
      PD_RUN: begin
        if (q.pdn && q.mode == OO_ON) begin
          n.pd       = PD_DELAY;
          n.tick_cnt = '0;
        end
      end
      PD_DELAY: begin
        // leaves the core time to stop itself before the analog goes
        if (tick) begin
          if (q.tick_cnt == `PMC_TICK_W'(`PMC_PD_DELAY_TICKS - 1)) begin
            n.pd       = PD_DOWN;
            n.tick_cnt = '0;
          end else begin
            n.tick_cnt = q.tick_cnt + `PMC_TICK_W'(1);
          end
        end
      end
      PD_DOWN: begin
        // without routing armed nothing wakes us
        if (q.route && wake_any) begin
          n.pd       = PD_WAKE;
          n.tick_cnt = '0;
        end
      end
      PD_WAKE: begin
        if (tick) begin
          if (q.tick_cnt == `PMC_TICK_W'(`PMC_WAKE_TICKS - 1)) begin
            n.pd  = PD_RUN;
            n.pdn = 1'b0;
          end else begin
            n.tick_cnt = q.tick_cnt + `PMC_TICK_W'(1);
          end
        end
      end
    endcase

    // axi write address and data, taken in either order
    if (i_axi.awvalid && q.awready) begin
      n.aw_hold = 1'b1;
      n.aw_idx  = i_axi.awaddr[`PMC_ADDR_W-1:2];
      n.awready = 1'b0;
    end
    if (i_axi.wvalid && q.wready) begin
      n.w_hold  = 1'b1;
      n.wdata   = i_axi.wdata[7:0];
      n.wstrb0  = i_axi.wstrb[0];
      n.wready  = 1'b0;
    end

    // axi read; a read of the routing register disarms it
    if (i_axi.arvalid && q.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = is_mapped(i_axi.araddr[`PMC_ADDR_W-1:2]) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      n.rdata   = 8'h00;
      unique case (i_axi.araddr[`PMC_ADDR_W-1:2])
        `PMC_IDX_DIV:   n.rdata[`PMC_DIV_LSB +: `PMC_DIV_W] = q.div;
        `PMC_IDX_MISC0: n.rdata[`PMC_PDN_BIT] = q.pdn;
        `PMC_IDX_ROUTE: begin
          n.rdata[`PMC_ROUTE_BIT] = q.route;
          n.route                 = 1'b0;
        end
        `PMC_IDX_CARD: begin
          n.rdata[`PMC_CARD_PDN_BIT]  = q.card_pdn;
          n.rdata[`PMC_ST_ON_BIT]     = (q.mode == OO_ON);
          n.rdata[`PMC_ST_OFFREQ_BIT] = q.off_req;
          n.rdata[`PMC_ST_BUS_BIT]    = bus_s;
          n.rdata[`PMC_ST_STBY_BIT]   = q.cpu_halt;
        end
        default: n.rdata = 8'h00;
      endcase
    end
    if (q.rvalid && i_axi.rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end

    // commit the write once both halves are in; software set beats hardware clear
    if (q.aw_hold && q.w_hold && !q.bvalid) begin
      n.aw_hold = 1'b0;
      n.w_hold  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = is_mapped(q.aw_idx) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      if (q.wstrb0) begin
        unique case (q.aw_idx)
          `PMC_IDX_DIV:   n.div = q.wdata[`PMC_DIV_LSB +: `PMC_DIV_W];
          `PMC_IDX_MISC0: begin
            // a clear is only honoured while running; mid-sequence it is ignored
            if (q.wdata[`PMC_PDN_BIT] || q.pd == PD_RUN) begin
              n.pdn = q.wdata[`PMC_PDN_BIT];
            end
          end
          `PMC_IDX_ROUTE: n.route = q.wdata[`PMC_ROUTE_BIT];
          `PMC_IDX_CARD:  n.card_pdn = q.wdata[`PMC_CARD_PDN_BIT];
          default: begin
          end
        endcase
      end
    end
    if (q.bvalid && i_axi.bready) begin
      n.bvalid  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end

    // supply and clock outputs from the next state
    n.core_en    = (n.mode == OO_ON);
    n.core_por   = (n.mode == OO_OFF) || (q.mode == OO_OFF);
    n.conv_en    = (n.mode == OO_ON);
    n.analog_en  = (n.mode == OO_ON) && (n.pd != PD_DOWN);
    n.cpu_halt   = (n.pd != PD_RUN);
    n.card_deact = (n.mode == OO_ON) && n.card_pdn;
    n.external_interrupt_zero       = (n.pd == PD_RUN) &&
                   (i_usr_int || (q.route && (i_card_int || i_keypad_int)));
  end

  // registers; every field resets to a constant
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q          <= '0;
      q.mode     <= OO_OFF;
      q.pd       <= PD_RUN;
      q.div      <= `PMC_DIV_RST;
      q.deb      <= 1'b1;
      q.core_por <= 1'b1;
      q.awready  <= 1'b1;
      q.wready   <= 1'b1;
      q.arready  <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flops
  assign o_bus_sw_en      = q.bus_sw;
  assign o_bat_sw_en      = q.bat_sw;
  assign o_core_supply_en = q.core_en;
  assign o_core_por       = q.core_por;
  assign o_converter_en   = q.conv_en;
  assign o_analog_en      = q.analog_en;
  assign o_cpu_halt       = q.cpu_halt;
  assign o_card_deact     = q.card_deact;
  assign o_off_req        = q.off_req;
  assign o_ext_external_interrupt_zero       = q.external_interrupt_zero;
  assign o_axi.awready    = q.awready;
  assign o_axi.wready     = q.wready;
  assign o_axi.bresp      = q.bresp;
  assign o_axi.bvalid     = q.bvalid;
  assign o_axi.arready    = q.arready;
  assign o_axi.rdata      = {24'h000000, q.rdata};
  assign o_axi.rresp      = q.rresp;
  assign o_axi.rvalid     = q.rvalid;

  // helper counters that only the checks below read
  logic [10:0] h_dly;   // ticks seen while waiting to shut analog down
  logic [10:0] h_wk;    // ticks seen during wake delay
  logic        h_prev;  // processor clock one cycle ago
  logic [6:0]  h_run;   // cycles the processor clock level has held
  logic [1:0]  h_ok;    // toggles since the divider last changed

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      h_dly  <= '0;
      h_wk   <= '0;
      h_prev <= 1'b0;
      h_run  <= '0;
      h_ok   <= '0;
    end else begin
      h_dly  <= (q.pd == PD_RUN) ? 11'h000 :
                ((q.pd == PD_DELAY && tick) ? h_dly + 11'h001 : h_dly);
      h_wk   <= (q.pd != PD_WAKE) ? 11'h000 : (tick ? h_wk + 11'h001 : h_wk);
      h_prev <= o_proc_clk;
      h_run  <= (o_proc_clk != h_prev) ? 7'h01 : h_run + 7'h01;
      if (n.div != q.div) begin
        h_ok <= 2'h0;
      end else if (o_proc_clk != h_prev && h_ok != 2'h3) begin
        h_ok <= h_ok + 2'h1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sw_excl_a: assert property (!(o_bus_sw_en && o_bat_sw_en))
    else $error("both supply switches closed");
  bus_prio_a: assert property (bus_s [*3] |-> o_bus_sw_en)
    else $error("bus supply not selected");
  bus_on_a: assert property (bus_s |=> q.mode == OO_ON)
    else $error("bus supply present but not on");
  offreq_hold_a: assert property ((o_off_req && q.mode == OO_ON && !q.card_pdn) |=> o_off_req)
    else $error("shutdown request dropped");
  por_up_a: assert property ($rose(o_core_supply_en) |-> o_core_por)
    else $error("core powered without reset");
  card_off_a: assert property ((q.card_pdn && q.mode == OO_ON && !bus_s)
                               |-> ##[1:3] (q.mode == OO_OFF || bus_s))
    else $error("card power-down did not reach off");
  halt_a: assert property (($rose(q.pdn) && q.mode == OO_ON) |=> o_cpu_halt)
    else $error("standby not entered");
  pd_delay_a: assert property (($fell(o_analog_en) && o_core_supply_en)
                               |-> h_dly == 11'd32)
    else $error("analog shutdown delay wrong");
  wake_len_a: assert property (($past(q.pd) == PD_WAKE && q.pd == PD_RUN && q.mode == OO_ON)
                               |-> h_wk == 11'd512)
    else $error("wake delay wrong");
  div_half_a: assert property ((o_proc_clk != h_prev && h_ok == 2'h3)
                               |-> h_run == {1'b0, q.div} + 7'h01)
    else $error("processor clock half period wrong");
  route_clr_a: assert property ((i_axi.arvalid && q.arready && !(q.aw_hold && q.w_hold) &&
                                 i_axi.araddr[`PMC_ADDR_W-1:2] == `PMC_IDX_ROUTE)
                                |=> (!q.route && o_axi.rvalid))
    else $error("routing bit not cleared by read");

  wake_c: cover property ((q.pd == PD_WAKE) ##1 (q.pd == PD_RUN));
  offreq_c: cover property ($rose(o_off_req));
  power_up_c: cover property ($rose(o_core_supply_en));
  card_off_c: cover property ($fell(o_core_supply_en));

endmodule

`default_nettype wire

// ---- tb/pmc_far_model.sv ----
// far-side model: switch contact, bus supply detector and wake sources
`timescale 1ns/100ps
`default_nettype none

module pmc_far_model (
  // clock
  input  wire logic       i_clk,
  // commands from the bench
  input  wire logic       i_press,
  input  wire logic       i_bus,
  input  wire logic [2:0] i_wake,
  // pins toward the block, idle at time zero
  output logic            o_onoff_n     = 1'b1,
  output logic            o_bus_present = 1'b0,
  output logic [2:0]      o_wake        = 3'h0
);
  // pins move just after the edge; the block synchronises switch and supply itself
  always_ff @(posedge i_clk) begin
    o_onoff_n     <= ~i_press;
    o_bus_present <= i_bus;
    o_wake        <= i_wake;
  end
endmodule

`default_nettype wire

// ---- tb/pmc_top_tb_top.sv ----
// self-checking bench for the power mode controller
`timescale 1ns/100ps
`default_nettype none
`include "pmc_cfg.svh"

module pmc_top_tb_top;
  import pmc_pkg::*;
  localparam int DEB = 20;       // short debounce keeps the run brief
  logic         clk    = 1'b0;   // master clock
  logic         arst_n = 1'b0;   // async reset
  pmc_axi_req_t axi    = '0;     // bus requests
  pmc_axi_rsp_t rsp;             // bus answers
  logic         press  = 1'b0;   // switch held down
  logic         bus    = 1'b0;   // bus supply applied
  logic [2:0]   wake   = 3'h0;   // usr, card, keypad
  logic         onoff_n, bus_p, pclk, bsw, bat, core, por, conv, ana, halt, deact, offr, external_interrupt_zero;
  logic [2:0]   wk;
  logic [31:0]  rd;
  logic [1:0]   rr;
  int           failures = 0;
  int           n_tests  = 0;
  int           n, k, d, ticks = 0;

  always #12.5 clk = ~clk;
  // processor clock ticks for the delay counts
  always @(posedge pclk) ticks++;

  pmc_far_model far_u (.i_clk(clk), .i_press(press), .i_bus(bus), .i_wake(wake),
    .o_onoff_n(onoff_n), .o_bus_present(bus_p), .o_wake(wk));

  pmc_top #(.DEBOUNCE_CYC(DEB)) dut_u (.i_clk(clk), .i_arst_n(arst_n), .i_axi(axi),
    .o_axi(rsp), .i_onoff_n(onoff_n), .i_bus_present(bus_p), .i_usr_int(wk[0]),
    .i_card_int(wk[1]), .i_keypad_int(wk[2]), .o_proc_clk(pclk), .o_bus_sw_en(bsw),
    .o_bat_sw_en(bat), .o_core_supply_en(core), .o_core_por(por), .o_converter_en(conv),
    .o_analog_en(ana), .o_cpu_halt(halt), .o_card_deact(deact), .o_off_req(offr),
    .o_ext_external_interrupt_zero(external_interrupt_zero));

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // count settled cycles until a signal takes a value, bounded
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // one write: address and data together, bready held until the answer
  task automatic axw(logic [15:0] idx, logic [7:0] dat);
    int t;
    @(posedge clk);
    axi.awaddr  <= {idx, 2'b00};
    axi.awvalid <= 1'b1;
    axi.wdata   <= {24'h0, dat};
    axi.wstrb   <= 4'hf;
    axi.wvalid  <= 1'b1;
    axi.bready  <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (rsp.awready === 1'b1) axi.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) axi.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && t < 100);
    if (t >= 100) failures++;
    axi.bready <= 1'b0;
  endtask

  // one read; data and response taken at the edge where rvalid is seen
  task automatic axr(logic [15:0] idx);
    int t;
    @(posedge clk);
    axi.araddr  <= {idx, 2'b00};
    axi.arvalid <= 1'b1;
    axi.rready  <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      if (rsp.arready === 1'b1) axi.arvalid <= 1'b0;
      rd = rsp.rdata;
      rr = rsp.rresp;
    end while (rsp.rvalid !== 1'b1 && t < 100);
    if (t >= 100) failures++;
    axi.rready <= 1'b0;
  endtask

  // break-before-make must hold on every cycle
  always @(negedge clk) if (bsw === 1'b1 && bat === 1'b1) check("both switches", 1, 0);

  initial begin
    n = $urandom(32'h8f514665);
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    check("core supply", core, 0);
    axr(`PMC_IDX_DIV);
    check("divider reset", rd, 32'h0c);
    axr(16'h0001);
    check("unmapped resp", rr, `PMC_RESP_SLVERR);
    $display("test reset done");
    // a bounce shorter than the debounce must restart the count
    press <= 1'b1;
    repeat (DEB / 2) @(posedge clk);
    press <= 1'b0;
    repeat (DEB) @(posedge clk);
    check("core after bounce", core, 0);
    press <= 1'b1;
    wait_for(core, 1'b1, DEB + 20);
    check("core after press", core, 1);
    check("reset held", por, 1);
    press <= 1'b0;
    $display("test switch on done");
    // divider: top value, random legal value, bottom legal value
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 63 : (i == 2) ? 2 : 2 + $urandom_range(61);
      axw(`PMC_IDX_DIV, d[7:0]);
      @(posedge pclk);
      wait_for(pclk, 1'b0, 200);
      check("half period", n, d + 1);
    end
    check("reset released", por, 0);
    check("converter on", conv, 1);
    $display("test divider done");
    // power-down then wake from each interrupt group in turn
    for (int i = 0; i < 3; i++) begin
      axw(`PMC_IDX_ROUTE, 8'h80);
      axw(`PMC_IDX_MISC0, 8'h80);
      k = ticks;
      wait_for(halt, 1'b1, 10);
      check("cpu halt", halt, 1);
      wait_for(ana, 1'b0, 400);
      check("analog delay", (ticks - k) inside {[31:33]}, 1);
      wake[i] <= 1'b1;
      wait_for(ana, 1'b1, 20);
      k = ticks;
      check("external_interrupt_zero early", external_interrupt_zero, 0);
      wait_for(external_interrupt_zero, 1'b1, 4000);
      check("wake delay", (ticks - k) inside {[510:514]}, 1);
      check("halt after wake", halt, 0);
      wake[i] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    axr(`PMC_IDX_ROUTE);
    check("routing old", rd[7], 1);
    axr(`PMC_IDX_ROUTE);
    check("routing cleared", rd[7], 0);
    $display("test power-down done");
    // long press while on only latches the request
    press <= 1'b1;
    wait_for(offr, 1'b1, DEB + 20);
    press <= 1'b0;
    repeat (2 * DEB) @(posedge clk);
    check("request latched", offr, 1);
    check("core stays on", core, 1);
    axw(`PMC_IDX_CARD, 8'h01);
    wait_for(core, 1'b0, 20);
    check("core off", core, 0);
    check("analog off", ana, 0);
    check("converter off", conv, 0);
    check("request cleared", offr, 0);
    $display("test card power-down done");
    // bus supply forces on and hides the switch
    bus <= 1'b1;
    wait_for(core, 1'b1, 30);
    wait_for(bsw, 1'b1, 4);
    check("bus switch", {bsw, bat}, 2'b10);
    press <= 1'b1;
    repeat (2 * DEB) @(posedge clk);
    press <= 1'b0;
    check("switch ignored", offr, 0);
    axw(`PMC_IDX_CARD, 8'h01);
    wait_for(deact, 1'b1, 4);
    check("card deactivated", {deact, core}, 2'b11);
    axw(`PMC_IDX_CARD, 8'h00);
    bus <= 1'b0;
    wait_for(bat, 1'b1, 20);
    check("battery switch", {bsw, bat, core}, 3'b011);
    $display("test bus supply done");
    wrap_up();
  end

  // cut a hang short
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule

`default_nettype wire
